// *** ataf_pkg.sv ***
// Purpose: shared constants and types for the format/identify block
// Assumes: AXI4-Lite register access, 16-bit host data words
// Notes:   identify words above 62 read zero here
`default_nettype none
package ataf_pkg;
   // ----------------------------------------------------------------
   // opcodes and fill
   // ----------------------------------------------------------------
   localparam logic [7:0]  OP_FORMAT   = 8'h50;
   localparam logic [7:0]  OP_IDENT    = 8'hEC;
   localparam logic [7:0]  FILL_PAT    = 8'hFF;
   // ----------------------------------------------------------------
   // register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [11:0] ADR_CMD     = 12'h000;
   localparam logic [11:0] ADR_TF      = 12'h004;
   localparam logic [11:0] ADR_MULT    = 12'h008;
   localparam logic [11:0] ADR_STAT    = 12'h00C;
   localparam int          STAT_CLR_B  = 8;
   localparam logic [1:0]  RESP_OK     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [31:0] TF_RST      = 32'h0000_0000;
   localparam logic [7:0]  MULT_RST    = 8'h00;
   // ----------------------------------------------------------------
   // sector framing
   // ----------------------------------------------------------------
   localparam logic [8:0]  SECT_WORDS  = 9'h100;
   localparam logic [8:0]  CNT_ZERO_AS = 9'h100;
   localparam logic [7:0]  LAST_IDX    = 8'hFF;
   localparam logic [7:0]  LAST_DEF    = 8'h3E;
   // ----------------------------------------------------------------
   // identify fixed words
   // ----------------------------------------------------------------
   localparam logic [15:0] W0_CONFIG   = 16'h045A;
   localparam logic [15:0] W0_REMOVE   = 16'h848A;
   localparam logic [15:0] W5_OBS      = 16'h0200;
   localparam logic [15:0] W20_BUFTYP  = 16'h0002;
   localparam logic [15:0] W21_BUFSZ   = 16'h0001;
   localparam logic [15:0] W22_RSV     = 16'h0004;
   localparam logic [15:0] W47_MAXMUL  = 16'h8001;
   localparam logic [15:0] W49_CAPS    = 16'h0F00;
   localparam logic [15:0] W50_CAPS    = 16'h4001;
   localparam logic [15:0] W51_PIO     = 16'h0200;
   localparam logic [15:0] W53_VALID   = 16'h0007;
   localparam logic [7:0]  W59_VALID   = 8'h01;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       lba_mode;
      logic [3:0] head;
      logic [7:0] cyl_hi;
      logic [7:0] cyl_lo;
      logic [7:0] sec_cnt;
   } ataf_tf_t;
   typedef struct packed {
      logic [27:0] lba;
      logic [7:0]  fill;
   } ataf_media_t;
   typedef enum logic [1:0] {
      ST_IDLE, ST_FMT_RX, ST_FMT_WR, ST_ID_TX
   } ataf_state_t;
endpackage
`default_nettype wire

// *** ataf_core.sv ***
// Purpose: format-track and identify-device command engine
// Assumes: host data words are 16 bits, one handshake per word
// Notes:   strings arrive as parameters, first character in top bits
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ataf_core
   import ataf_pkg::*;
#(
   parameter logic [31:0]  CAPACITY = 32'h0000_0000,
   parameter logic [15:0]  CYLS     = 16'h0000,
   parameter logic [15:0]  HEADS    = 16'h0000,
   parameter logic [15:0]  SPT      = 16'h0000,
   parameter logic [159:0] SERIAL   = 160'h0,
   parameter logic [63:0]  FW_REV   = 64'h0,
   parameter logic [319:0] MODEL    = 320'h0
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   // axi4-lite slave
   input  wire logic [11:0] s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [11:0] s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // host write data (format sector)
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_valid,
   output logic             wr_ready,
   // host read data (identify)
   output logic [15:0]      id_data,
   output logic             id_valid,
   input  wire logic        id_ready,
   // media sector write requests
   output ataf_media_t      med_req,
   output logic             med_valid,
   input  wire logic        med_ready
);
   // ----------------------------------------------------------------
   // identify word decode
   // ----------------------------------------------------------------
   function automatic logic [15:0] id_word(input logic [7:0] i,
                                           input logic [7:0] mult);
      logic [15:0] w;
      w = 16'h0000;
      if (i >= 8'd10 && i <= 8'd19)
         w = SERIAL[159 - 16 * (i - 8'd10) -: 16];
      else if (i >= 8'd23 && i <= 8'd26)
         w = FW_REV[63 - 16 * (i - 8'd23) -: 16];
      else if (i >= 8'd27 && i <= 8'd46)
         w = MODEL[319 - 16 * (i - 8'd27) -: 16];
      else begin
         unique case (i)
            8'd0:    w = W0_CONFIG;
            8'd1:    w = CYLS;
            8'd3:    w = {8'h00, HEADS[7:0]};
            8'd5:    w = W5_OBS;
            8'd6:    w = SPT;
            8'd7:    w = CAPACITY[31:16];
            8'd8:    w = CAPACITY[15:0];
            8'd20:   w = W20_BUFTYP;
            8'd21:   w = W21_BUFSZ;
            8'd22:   w = W22_RSV;
            8'd47:   w = W47_MAXMUL;
            8'd49:   w = W49_CAPS;
            8'd50:   w = W50_CAPS;
            8'd51:   w = W51_PIO;
            8'd53:   w = W53_VALID;
            8'd54:   w = CYLS;
            8'd55:   w = HEADS;
            8'd56:   w = SPT;
            8'd57:   w = CAPACITY[15:0];
            8'd58:   w = CAPACITY[31:16];
            8'd59:   w = {W59_VALID, mult};
            8'd60:   w = CAPACITY[15:0];
            8'd61:   w = {4'h0, CAPACITY[27:16]};
            default: w = 16'h0000;
         endcase
      end
      return w;
   endfunction

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[8*b +: 8] = n[8*b +: 8];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ataf_state_t  state_r;
   ataf_tf_t     tf_r;
   logic [7:0]   mult_r;
   logic [7:0]   last_op_r;
   logic         abort_r;
   logic [8:0]   rx_cnt_r;
   logic [8:0]   left_r;
   logic [27:0]  lba_r;
   logic [8:0]   ld_cnt_r;
   logic [7:0]   out_idx_r;
   logic [15:0]  id_data_r;
   logic         id_valid_r;
   logic         aw_full_r;
   logic         w_full_r;
   logic [11:0]  aw_addr_r;
   logic [31:0]  w_data_r;
   logic [3:0]   w_strb_r;
   logic         bvalid_r;
   logic [1:0]   bresp_r;
   logic         rvalid_r;
   logic [31:0]  rdata_r;
   logic [1:0]   rresp_r;
   logic         do_wr;
   logic         cmd_wr;
   logic         busy;
   logic         id_load;
   logic         rx_hs;
   logic         med_hs;
   logic [31:0]  tf_mrg;

   assign busy    = (state_r != ST_IDLE);
   assign do_wr   = ce && aw_full_r && w_full_r && !bvalid_r;
   assign cmd_wr  = do_wr && (aw_addr_r == ADR_CMD) && w_strb_r[0];
   assign rx_hs   = ce && wr_valid && wr_ready;
   assign med_hs  = ce && med_valid && med_ready;
   assign tf_mrg  = merge({3'h0, tf_r}, w_data_r, w_strb_r);
   assign id_load = ce && (state_r == ST_ID_TX) && (ld_cnt_r != SECT_WORDS)
                    && (!id_valid_r || id_ready);

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   assign s_awready = !aw_full_r;
   assign s_wready  = !w_full_r;
   assign s_bvalid  = bvalid_r;
   assign s_bresp   = bresp_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OK;
      end else if (ce) begin
         if (s_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_awaddr;
         end
         if (s_wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            w_data_r <= s_wdata;
            w_strb_r <= s_wstrb;
         end
         if (do_wr) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (aw_addr_r[11:4] == 8'h00 && aw_addr_r[1:0] == 2'h0)
                         ? RESP_OK : RESP_SLVERR;
         end else if (bvalid_r && s_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // task file and multiple setting; frozen while a command runs
   always_ff @(posedge clock) begin
      if (rst) begin
         tf_r   <= ataf_tf_t'(TF_RST[28:0]);
         mult_r <= MULT_RST;
      end else if (do_wr && !busy) begin
         if (aw_addr_r == ADR_TF)
            tf_r <= ataf_tf_t'(tf_mrg[28:0]);
         if (aw_addr_r == ADR_MULT && w_strb_r[0])
            mult_r <= w_data_r[7:0];
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   assign s_arready = !rvalid_r;
   assign s_rvalid  = rvalid_r;
   assign s_rdata   = rdata_r;
   assign s_rresp   = rresp_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OK;
      end else if (ce) begin
         if (s_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= RESP_OK;
            unique case (s_araddr)
               ADR_CMD:  rdata_r <= {24'h0, last_op_r};
               ADR_TF:   rdata_r <= {3'h0, tf_r};
               ADR_MULT: rdata_r <= {24'h0, mult_r};
               ADR_STAT: rdata_r <= {7'h0, left_r, 7'h0, abort_r,
                                     5'h0, busy, state_r};
               default: begin
                  rdata_r <= 32'h0000_0000;
                  rresp_r <= RESP_SLVERR;
               end
            endcase
         end else if (rvalid_r && s_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   // commands written while busy are dropped, not queued
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r   <= ST_IDLE;
         last_op_r <= 8'h00;
         rx_cnt_r  <= 9'h000;
         left_r    <= 9'h000;
         lba_r     <= 28'h0;
      end else if (ce) begin
         unique case (state_r)
            ST_IDLE: begin
               if (cmd_wr) begin
                  last_op_r <= w_data_r[7:0];
                  rx_cnt_r  <= 9'h000;
                  if (w_data_r[7:0] == OP_FORMAT) begin
                     state_r <= ST_FMT_RX;
                     lba_r   <= {tf_r.head, tf_r.cyl_hi, tf_r.cyl_lo,
                                 tf_r.lba_mode ? 8'h00 : 8'h01};
                     if (tf_r.lba_mode)
                        left_r <= (tf_r.sec_cnt == 8'h00) ? CNT_ZERO_AS
                                  : {1'b0, tf_r.sec_cnt};
                     else
                        left_r <= SPT[8:0];
                  end else if (w_data_r[7:0] == OP_IDENT) begin
                     state_r <= ST_ID_TX;
                  end
               end
            end
            ST_FMT_RX: begin
               // payload dropped on the floor; nothing latches wr_data
               if (rx_hs) begin
                  rx_cnt_r <= rx_cnt_r + 9'h001;
                  if (rx_cnt_r == SECT_WORDS - 9'h001)
                     state_r <= ST_FMT_WR;
               end
            end
            ST_FMT_WR: begin
               if (med_hs) begin
                  lba_r  <= lba_r + 28'h1;
                  left_r <= left_r - 9'h001;
                  if (left_r <= 9'h001)
                     state_r <= ST_IDLE;
               end else if (left_r == 9'h000) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_ID_TX: begin
               if (ld_cnt_r == SECT_WORDS && (!id_valid_r || id_ready))
                  state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // unknown opcode aborts; a new abort beats a clear
   always_ff @(posedge clock) begin
      if (rst)
         abort_r <= 1'b0;
      else if (cmd_wr && !busy && w_data_r[7:0] != OP_FORMAT
               && w_data_r[7:0] != OP_IDENT)
         abort_r <= 1'b1;
      else if (do_wr && aw_addr_r == ADR_STAT && w_strb_r[1]
               && w_data_r[STAT_CLR_B])
         abort_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // host data paths
   // ----------------------------------------------------------------
   assign wr_ready      = (state_r == ST_FMT_RX);
   assign med_valid     = (state_r == ST_FMT_WR) && (left_r != 9'h000);
   assign med_req.lba   = lba_r;
   assign med_req.fill  = FILL_PAT;
   assign id_valid      = id_valid_r;
   assign id_data       = id_data_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         ld_cnt_r   <= 9'h000;
         out_idx_r  <= 8'h00;
         id_data_r  <= 16'h0000;
         id_valid_r <= 1'b0;
      end else if (ce) begin
         if (cmd_wr && !busy)
            ld_cnt_r <= 9'h000;
         if (id_load) begin
            id_data_r  <= id_word(ld_cnt_r[7:0], mult_r);
            out_idx_r  <= ld_cnt_r[7:0];
            id_valid_r <= 1'b1;
            ld_cnt_r   <= ld_cnt_r + 9'h001;
         end else if (id_valid_r && id_ready) begin
            id_valid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_fill_fixed: assert property (@(posedge clock) disable iff (rst)
      med_valid |-> med_req.fill == 8'hFF)
      else $error("fill pattern not fixed");
   a_rx_no_media: assert property (@(posedge clock) disable iff (rst)
      state_r == ST_FMT_RX |-> !med_valid && !id_valid)
      else $error("media write during data sector");
   a_lba_count: assert property (@(posedge clock) disable iff (rst)
      cmd_wr && !busy && w_data_r[7:0] == 8'h50 && tf_r.lba_mode
      |=> left_r == ((tf_r.sec_cnt == 8'h00) ? 9'd256
                     : {1'b0, tf_r.sec_cnt}))
      else $error("format count wrong");
   a_start_addr: assert property (@(posedge clock) disable iff (rst)
      $rose(state_r == ST_FMT_WR) |-> lba_r[23:8] ==
      {tf_r.cyl_hi, tf_r.cyl_lo})
      else $error("format start address wrong");
   a_id_hold: assert property (@(posedge clock) disable iff (rst)
      id_valid && !id_ready |=> id_valid && $stable(id_data))
      else $error("identify word dropped");
   a_word0_cfg: assert property (@(posedge clock) disable iff (rst)
      id_valid && out_idx_r == 8'h00 |-> id_data == 16'h045A)
      else $error("word 0 wrong");
   a_mult_echo: assert property (@(posedge clock) disable iff (rst)
      id_valid && out_idx_r == 8'd59 |-> id_data[7:0] == mult_r)
      else $error("word 59 stale");
   a_tail_zero: assert property (@(posedge clock) disable iff (rst)
      id_valid && out_idx_r > LAST_DEF |-> id_data == 16'h0000)
      else $error("reserved word not zero");
   a_sector_end: assert property (@(posedge clock) disable iff (rst)
      ce && id_valid && id_ready && out_idx_r == LAST_IDX
      |=> state_r == ST_IDLE && !id_valid)
      else $error("identify length wrong");
endmodule
`default_nettype wire

// *** ataf_pkg_unused_guard.sv ***
`default_nettype none
`default_nettype wire

// *** ataf_media_sink.sv ***
// Purpose: media side stand-in that accepts sector write requests
// Assumes: one request per med_valid/med_ready handshake
// Notes:   stalls one cycle in four so requests must hold while waiting
`timescale 1ns/1ps
`default_nettype none
module ataf_media_sink
   import ataf_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // request channel
   input  wire ataf_media_t med_req,
   input  wire logic        med_valid,
   output logic             med_ready
);
   logic [1:0] stall_r;

   // ----------------------------------------------------------------
   // stall pattern
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         stall_r <= 2'h0;
      end else begin
         stall_r <= stall_r + 2'h1;
      end
   end
   // no flow control on the data itself, a real medium may wait longer
   assign med_ready = (stall_r != 2'h3);
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for the format/identify engine
// Assumes: register map and timing as handed over by the designer
// Notes:   identify image is rebuilt here from the chosen parameters
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ataf_pkg::*;
   localparam logic [31:0]  CAP_P = 32'h1A12_3456;
   localparam logic [15:0]  CYL_P = 16'h0100;
   localparam logic [15:0]  HD_P  = 16'h0010;
   localparam logic [15:0]  SPT_P = 16'h003F;
   localparam logic [159:0] SER_P = {{12{8'h20}}, "SER00042"};
   localparam logic [63:0]  FW_P  = "FW1.0.00";
   localparam logic [319:0] MOD_P = {{27{8'h20}}, "FLASHMODULEX1"};

   logic        clock, rst, ce;
   logic [11:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
   logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic [15:0] wr_data, id_data;
   logic        wr_valid, wr_ready, id_valid, id_ready;
   ataf_media_t med_req;
   logic        med_valid, med_ready;
   int          num_errors, tests_run, cyc, med_cnt;
   logic [27:0] exp_lba;

   ataf_core #(.CAPACITY(CAP_P), .CYLS(CYL_P), .HEADS(HD_P), .SPT(SPT_P),
      .SERIAL(SER_P), .FW_REV(FW_P), .MODEL(MOD_P)) u_ataf_core (
      .clock(clock), .rst(rst), .ce(ce),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready),
      .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .id_data(id_data), .id_valid(id_valid), .id_ready(id_ready),
      .med_req(med_req), .med_valid(med_valid), .med_ready(med_ready));
   ataf_media_sink u_ataf_media_sink (.clock(clock), .rst(rst),
      .med_req(med_req), .med_valid(med_valid), .med_ready(med_ready));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("compares %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hF;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge clock);
         if (!aw_d && s_awready === 1'b1) begin
            aw_d = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (!w_d && s_wready === 1'b1) begin
            w_d = 1'b1;
            s_wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (s_bvalid !== 1'b1);
      r = s_bresp;
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge clock); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge clock); while (s_rvalid !== 1'b1);
      d = s_rdata;
      r = s_rresp;
   endtask

   function automatic logic [15:0] exp_word(input int i,
                                            input logic [7:0] m);
      logic [15:0] w;
      w = 16'h0000;
      case (i)
         0: w = 16'h045A;
         1: w = CYL_P;
         3: w = {8'h00, HD_P[7:0]};
         5: w = 16'h0200;
         6: w = SPT_P;
         7: w = CAP_P[31:16];
         8: w = CAP_P[15:0];
         20: w = 16'h0002;
         21: w = 16'h0001;
         22: w = 16'h0004;
         47: w = 16'h8001;
         49: w = 16'h0F00;
         50: w = 16'h4001;
         51: w = 16'h0200;
         53: w = 16'h0007;
         54: w = CYL_P;
         55: w = HD_P;
         56: w = SPT_P;
         57: w = CAP_P[15:0];
         58: w = CAP_P[31:16];
         59: w = {8'h01, m};
         60: w = CAP_P[15:0];
         61: w = {4'h0, CAP_P[27:16]};
         default: begin
            if (i >= 10 && i <= 19) w = SER_P[(19 - i) * 16 +: 16];
            if (i >= 23 && i <= 26) w = FW_P[(26 - i) * 16 +: 16];
            if (i >= 27 && i <= 46) w = MOD_P[(46 - i) * 16 +: 16];
         end
      endcase
      return w;
   endfunction

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(ADR_TF, d, r);
      cmp(d, 32'h0);
      axi_wr(12'h010, 32'h1234, r);
      cmp({30'h0, r}, 32'h2);
      axi_rd(12'h014, d, r);
      cmp({r, d[29:0]}, 32'h8000_0000);
      axi_wr(ADR_CMD, 32'h33, r);
      axi_rd(ADR_STAT, d, r);
      cmp({31'h0, d[8]}, 32'h1);
      axi_rd(ADR_CMD, d, r);
      cmp(d, 32'h33);
      axi_wr(ADR_STAT, 32'h100, r);
      axi_rd(ADR_STAT, d, r);
      cmp({31'h0, d[8]}, 32'h0);
      $display("test registers done");
   endtask

   task automatic t_ident(input logic [7:0] m);
      int          i, k;
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(ADR_MULT, {24'h0, m}, r);
      axi_wr(ADR_CMD, 32'hEC, r);
      i = 0;
      k = 0;
      while (i < 256) begin
         id_ready <= (k % 3 != 2);
         ce <= (k % 7 != 3);
         @(posedge clock);
         if (id_valid === 1'b1 && id_ready && ce) begin
            cmp({16'h0, id_data}, {16'h0, exp_word(i, m)});
            i++;
         end
         k++;
      end
      @(posedge clock);
      cmp({31'h0, id_valid}, 32'h0);
      id_ready <= 1'b0;
      axi_rd(ADR_STAT, d, r);
      cmp({29'h0, d[2:0]}, 32'h0);
      $display("test identify done");
   endtask

   task automatic t_fmt(input logic [28:0] tf, input logic [27:0] st,
                        input int n);
      int          i;
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(ADR_TF, {3'h0, tf}, r);
      exp_lba = st;
      med_cnt = 0;
      axi_wr(ADR_CMD, 32'h50, r);
      i = 0;
      wr_valid <= 1'b1;
      while (i < 256) begin
         @(posedge clock);
         if (wr_ready === 1'b1) begin
            i++;
            wr_data <= 16'(i * 16'h3C71);
         end
      end
      wr_valid <= 1'b0;
      cmp(32'(med_cnt), 32'h0);
      do axi_rd(ADR_STAT, d, r); while (d[2] !== 1'b0);
      cmp(32'(med_cnt), 32'(n));
      $display("test format done");
   endtask

   // media requests carry the fixed fill and consecutive addresses
   always @(posedge clock) begin
      if (med_valid === 1'b1 && med_ready === 1'b1) begin
         cmp({4'h0, med_req.lba}, {4'h0, exp_lba});
         cmp({24'h0, med_req.fill}, 32'hFF);
         exp_lba = exp_lba + 28'h1;
         med_cnt++;
      end
   end

   // ----------------------------------------------------------------
   // clock, timeout, main
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      {rst, ce} = 2'b11;
      {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {wr_data, wr_valid, id_ready} = '0;
      {num_errors, tests_run, cyc, med_cnt} = '0;
      exp_lba = 28'h0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_ident(8'h08);
      t_ident(8'h10);
      t_fmt({1'b1, 4'h3, 8'h12, 8'h34, 8'h02}, 28'h312_3400, 2);
      t_fmt({1'b1, 4'h5, 8'hAB, 8'hCD, 8'h00}, 28'h5AB_CD00, 256);
      t_fmt({1'b0, 4'h1, 8'h00, 8'h07, 8'h05}, 28'h100_0701, 63);
      end_of_test();
   end
endmodule
`default_nettype wire
